// ==== trb_table_read.sv ====
// Operation
// - Current-page pointer is offset in page
// - Table read loads high byte automatically
// - Table-high latch is read only
// - Table reads take two cycles
// - Data memory bytes are eight bits
// - Some special registers are write protected
// - General purpose bytes are read/write
// - Special space mirrors; 40H only bank one
// - Bank select pointer chooses the bank
// - Data space starts at address 00H
// - Low byte goes to operand location
// - Unused high latch bits read zero
// - Page bits from PC or all ones for last page, low from pointer
// - Table address 11 or 12 bits
`timescale 1ns/100ps
`default_nettype none
module trb_table_read #(
  parameter int PA_W   = 11,  // Table address width, 11 or 12
  parameter int PW_W   = 15,  // Program word width, 15 or 16
  parameter int BANK_W = 2    // Bank pointer width
) (
  // Clock and reset
  input  wire logic                 I_SYS_CLK,
  input  wire logic                 I_SRST,
  // Execution unit
  input  wire trb_pkg::trb_mem_req_t I_MEM_REQ,
  input  wire trb_pkg::trb_tbl_req_t I_TBL_REQ,
  input  wire logic [PA_W-1:0]      I_PC,
  output logic [7:0]                O_RDATA,
  output logic                      O_BUSY,
  // Program memory port
  output logic [PA_W-1:0]           O_PM_ADDR,
  output logic                      O_PM_RD,
  input  wire logic [PW_W-1:0]      I_PM_DATA
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef enum logic {TRB_IDLE, TRB_FETCH} trb_st_t;

  trb_st_t                   st_q, st_d;            // Sequencer
  logic [7:0]                dest_q, dest_d;        // Latched destination
  logic [PA_W-1:0]           paddr_q, paddr_d;      // Latched table address
  logic [7:0]                tbl_high_q, tbl_high_d;// Table-high latch
  logic [7:0]                bank_q, bank_d;        // Bank select pointer byte
  logic [7:0]                ptr_q, ptr_d;          // Table pointer low
  logic [7:0]                page_q, page_d;        // Table pointer high
  logic [7:0]                nv_q, nv_d;            // Nonvolatile control byte
  logic [7:0]                sfr_q [0:trb_pkg::GP_BASE_ADDR-1];  // Other special bytes
  logic [7:0]                sfr_d [0:trb_pkg::GP_BASE_ADDR-1];
  localparam int             GP_N = (1 << BANK_W) * 256;
  logic [7:0]                gp_q  [0:GP_N-1];      // General bytes, flat by bank
  logic [7:0]                gp_d  [0:GP_N-1];

  // Decode for software access and for table destination
  trb_pkg::trb_dec_t         dec;
  logic [BANK_W+7:0]         gp_idx;
  logic [7:0]                dec_addr;
  logic [7:0]                rd_d, rd_q;

  // Address the decoder with the table destination during a write-back
  assign dec_addr = (st_q == TRB_FETCH) ? dest_q : I_MEM_REQ.addr;

  trb_ram_decode #(.BANK_W(BANK_W)) u_dec (
    .i_addr     (dec_addr),
    .i_bank     (bank_q[BANK_W-1:0]),
    .o_dec      (dec),
    .o_gp_index (gp_idx)
  );

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Form table address from page source and pointer
  function automatic logic [PA_W-1:0] tbl_addr(input logic last_pg, input logic [PA_W-1:0] pc,
                                               input logic [7:0] ptr);
    logic [PA_W-1:0] hi;
    hi = last_pg ? {PA_W{1'b1}} : pc;  // All-ones last page, else page of executing instruction
    return {hi[PA_W-1:8], ptr};  // Width follows variant
  endfunction : tbl_addr

  // Busy both cycles so the core stretches the instruction
  assign O_BUSY    = I_TBL_REQ.start | (st_q == TRB_FETCH);
  assign O_PM_ADDR = paddr_q;
  assign O_PM_RD   = (st_q == TRB_FETCH);
  assign O_RDATA   = rd_q;

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  always_comb begin
    st_d       = st_q;
    dest_d     = dest_q;
    paddr_d    = paddr_q;
    tbl_high_d = tbl_high_q;
    bank_d     = bank_q;
    ptr_d      = ptr_q;
    page_d     = page_q;
    nv_d       = nv_q;
    sfr_d      = sfr_q;
    gp_d       = gp_q;
    rd_d       = trb_pkg::IND_READ_VALUE;
    case (st_q)
      TRB_IDLE: begin
        if (I_TBL_REQ.start) begin
          // First cycle: capture address and destination
          st_d    = TRB_FETCH;
          dest_d  = I_TBL_REQ.dest;
          paddr_d = tbl_addr(I_TBL_REQ.last_pg, I_PC, ptr_q);
        end else if (I_MEM_REQ.acc == trb_pkg::TRB_ACC_WRITE) begin
          case (dec)
            trb_pkg::TRB_DEC_GP:     gp_d[gp_idx] = I_MEM_REQ.wdata;
            trb_pkg::TRB_DEC_NV:     nv_d = I_MEM_REQ.wdata;
            trb_pkg::TRB_DEC_SFR_RO: tbl_high_d = tbl_high_q;  // Write ignored
            trb_pkg::TRB_DEC_SFR: begin
              if (I_MEM_REQ.addr == trb_pkg::BANK_SEL_ADDR) begin
                bank_d = I_MEM_REQ.wdata;  // Software switches banks
              end else if (I_MEM_REQ.addr == trb_pkg::TBL_PTR_ADDR) begin
                ptr_d = I_MEM_REQ.wdata;
              end else if (I_MEM_REQ.addr == trb_pkg::TBL_PAGE_ADDR) begin
                page_d = I_MEM_REQ.wdata;
              end else begin
                sfr_d[I_MEM_REQ.addr[6:0]] = I_MEM_REQ.wdata;
              end
            end
            default: ;  // Not decoded in this bank
          endcase
        end else if (I_MEM_REQ.acc == trb_pkg::TRB_ACC_READ) begin
          case (dec)
            trb_pkg::TRB_DEC_GP:     rd_d = gp_q[gp_idx];
            trb_pkg::TRB_DEC_NV:     rd_d = nv_q;
            trb_pkg::TRB_DEC_SFR_RO: rd_d = tbl_high_q;
            trb_pkg::TRB_DEC_SFR: begin
              if (I_MEM_REQ.addr == trb_pkg::BANK_SEL_ADDR) begin
                rd_d = bank_q;
              end else if (I_MEM_REQ.addr == trb_pkg::TBL_PTR_ADDR) begin
                rd_d = ptr_q;
              end else if (I_MEM_REQ.addr == trb_pkg::TBL_PAGE_ADDR) begin
                rd_d = page_q;
              end else begin
                rd_d = sfr_q[I_MEM_REQ.addr[6:0]];
              end
            end
            default: rd_d = trb_pkg::IND_READ_VALUE;  // Undecoded reads zero
          endcase
        end
      end
      TRB_FETCH: begin
        // Second cycle: word arrives, latch and decoded destination written together; a latch destination keeps only the high byte
        st_d       = TRB_IDLE;
        tbl_high_d = 8'h00;
        tbl_high_d[PW_W-9:0] = I_PM_DATA[PW_W-1:8];  // Auto load, upper bits zero
        case (dec)
          trb_pkg::TRB_DEC_GP: gp_d[gp_idx] = I_PM_DATA[7:0];  // Low byte to operand
          trb_pkg::TRB_DEC_NV: nv_d = I_PM_DATA[7:0];
          trb_pkg::TRB_DEC_SFR: begin
            if (dest_q == trb_pkg::BANK_SEL_ADDR) begin
              bank_d = I_PM_DATA[7:0];
            end else if (dest_q == trb_pkg::TBL_PTR_ADDR) begin
              ptr_d = I_PM_DATA[7:0];
            end else if (dest_q == trb_pkg::TBL_PAGE_ADDR) begin
              page_d = I_PM_DATA[7:0];
            end else begin
              sfr_d[dest_q[6:0]] = I_PM_DATA[7:0];
            end
          end
          default: ;  // Latch itself keeps the fetched high byte
        endcase
      end
      default: st_d = TRB_IDLE;
    endcase
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  // Data memory is volatile; only control and pointers are reset
  always_ff @(posedge I_SYS_CLK) begin
    if (I_SRST) begin
      st_q       <= TRB_IDLE;
      dest_q     <= trb_pkg::BYTE_RESET;
      paddr_q    <= '0;
      tbl_high_q <= trb_pkg::BYTE_RESET;
      bank_q     <= {6'h00, trb_pkg::BANK_SEL_RESET};
      ptr_q      <= trb_pkg::BYTE_RESET;
      page_q     <= trb_pkg::BYTE_RESET;
      nv_q       <= trb_pkg::BYTE_RESET;
      rd_q       <= trb_pkg::BYTE_RESET;
    end else begin
      st_q       <= st_d;
      dest_q     <= dest_d;
      paddr_q    <= paddr_d;
      tbl_high_q <= tbl_high_d;
      bank_q     <= bank_d;
      ptr_q      <= ptr_d;
      page_q     <= page_d;
      nv_q       <= nv_d;
      rd_q       <= rd_d;
    end
  end

  // Unreset storage arrays
  always_ff @(posedge I_SYS_CLK) begin
    sfr_q <= sfr_d;
    gp_q  <= gp_d;
  end

endmodule : trb_table_read
`default_nettype wire

// ==== trb_pkg.sv ====
package trb_pkg;

  // ----------------------------------------
  // Data memory map
  // ----------------------------------------
  localparam logic [7:0] SFR_BASE_ADDR   = 8'h00;  // Data space starts here in every variant
  localparam logic [7:0] NV_CTRL_ADDR    = 8'h40;  // Nonvolatile control, bank 1 only
  localparam logic [7:0] BANK_SEL_ADDR   = 8'h04;  // Bank select pointer
  localparam logic [7:0] TBL_PTR_ADDR    = 8'h07;  // Table pointer low
  localparam logic [7:0] TBL_HIGH_ADDR   = 8'h08;  // Table-high latch
  localparam logic [7:0] TBL_PAGE_ADDR   = 8'h09;  // Table pointer high
  localparam logic [7:0] GP_BASE_ADDR    = 8'h60;  // First general purpose byte
  localparam logic [1:0] NV_CTRL_BANK    = 2'h1;   // Bank in which nonvolatile control decodes
  localparam logic [1:0] BANK_SEL_RESET  = 2'h0;   // Bank after reset
  localparam logic [7:0] BYTE_RESET      = 8'h00;  // Value of held bytes after reset
  localparam logic [7:0] IND_READ_VALUE  = 8'h00;  // Value of an unimplemented location
  localparam int         TBL_CYCLES      = 2;      // Instruction cycles of a table read

  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef enum logic [1:0] {TRB_ACC_NONE, TRB_ACC_READ, TRB_ACC_WRITE} trb_acc_t;

  // Data memory request from execution unit
  typedef struct packed {
    trb_acc_t   acc;
    logic [7:0] addr;
    logic [7:0] wdata;
  } trb_mem_req_t;

  // Table read request
  typedef struct packed {
    logic       start;   // Pulse, first cycle of instruction
    logic       last_pg; // 1: fixed last page, 0: current page
    logic [7:0] dest;    // Destination data address
  } trb_tbl_req_t;

  // Decode result
  typedef enum logic [2:0] {TRB_DEC_SFR, TRB_DEC_SFR_RO, TRB_DEC_GP, TRB_DEC_NV, TRB_DEC_NONE}
    trb_dec_t;

endpackage : trb_pkg

// ==== trb_ram_decode.sv ====
`timescale 1ns/100ps
`default_nettype none
module trb_ram_decode #(
  parameter int BANK_W = 2
) (
  // Address and bank
  input  wire logic [7:0]        i_addr,
  input  wire logic [BANK_W-1:0] i_bank,
  // Result
  output trb_pkg::trb_dec_t      o_dec,
  output logic [BANK_W+7:0]      o_gp_index
);

  // ----------------------------------------
  // Combinational decode
  // ----------------------------------------
  // Special space below the general area mirrors across banks, except 40H
  always_comb begin
    o_gp_index = {i_bank, i_addr};  // Bank selects which general byte is hit
    if (i_addr >= trb_pkg::GP_BASE_ADDR) begin
      o_dec = trb_pkg::TRB_DEC_GP;  // Always read and write
    end else if (i_addr == trb_pkg::NV_CTRL_ADDR) begin
      // Only bank 1 sees the nonvolatile control byte
      o_dec = (i_bank == BANK_W'(trb_pkg::NV_CTRL_BANK)) ? trb_pkg::TRB_DEC_NV : trb_pkg::TRB_DEC_NONE;
    end else if (i_addr == trb_pkg::TBL_HIGH_ADDR) begin
      o_dec = trb_pkg::TRB_DEC_SFR_RO;  // Protected from software
    end else begin
      o_dec = trb_pkg::TRB_DEC_SFR;  // Same decode in every bank
    end
  end

endmodule : trb_ram_decode
`default_nettype wire

// ==== trb_table_read_checker.sv ====
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// Port checker
// ----------------------------------------
module trb_table_read_checker #(
  parameter int PA_W   = 11,
  parameter int PW_W   = 15,
  parameter int BANK_W = 2
) (
  // Top ports
  input wire logic                  I_SYS_CLK,
  input wire logic                  I_SRST,
  input wire trb_pkg::trb_mem_req_t I_MEM_REQ,
  input wire trb_pkg::trb_tbl_req_t I_TBL_REQ,
  input wire logic [PA_W-1:0]       I_PC,
  input wire logic [7:0]            O_RDATA,
  input wire logic                  O_BUSY,
  input wire logic [PA_W-1:0]       O_PM_ADDR,
  input wire logic                  O_PM_RD,
  input wire logic [PW_W-1:0]       I_PM_DATA
);
  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (I_SRST);
  // Read really taken; table cycles swallow it
  logic rd_take;
  assign rd_take = (I_MEM_REQ.acc == trb_pkg::TRB_ACC_READ) && !I_TBL_REQ.start && !O_PM_RD;
  AST_BUSY_START: assert property (I_TBL_REQ.start |-> O_BUSY) else $error("busy low at start");
  AST_BUSY_CAUSE: assert property (O_BUSY |-> I_TBL_REQ.start || O_PM_RD) else $error("stray busy");
  AST_FETCH_NEXT: assert property (I_TBL_REQ.start |=> O_PM_RD && O_BUSY) else $error("no fetch");
  AST_FETCH_CAUSE: assert property (O_PM_RD |-> $past(I_TBL_REQ.start)) else $error("stray fetch");
  AST_FETCH_ONE: assert property (O_PM_RD |=> !O_PM_RD) else $error("fetch too long");
  AST_CUR_PAGE: assert property (I_TBL_REQ.start && !I_TBL_REQ.last_pg |=>
    O_PM_ADDR[PA_W-1:8] == $past(I_PC[PA_W-1:8])) else $error("page bits wrong");
  AST_LAST_PAGE: assert property (I_TBL_REQ.start && I_TBL_REQ.last_pg |=>
    &O_PM_ADDR[PA_W-1:8]) else $error("last page wrong");
  AST_RDATA_IDLE: assert property (!rd_take |=> O_RDATA == 8'h00) else $error("idle data");
  AST_LATCH_READ: assert property (O_PM_RD ##1 (rd_take && I_MEM_REQ.addr == trb_pkg::TBL_HIGH_ADDR)
    |=> O_RDATA == 8'($past(I_PM_DATA, 2) >> 8)) else $error("latch value wrong");
  // Main scenarios
  COV_CUR: cover property (I_TBL_REQ.start && !I_TBL_REQ.last_pg);
  COV_LAST: cover property (I_TBL_REQ.start && I_TBL_REQ.last_pg);
  COV_LATCH: cover property (O_PM_RD ##1 rd_take ##5 rd_take);
endmodule : trb_table_read_checker
bind trb_table_read trb_table_read_checker #(.PA_W(PA_W), .PW_W(PW_W), .BANK_W(BANK_W))
  u_trb_table_read_checker (.I_SYS_CLK(I_SYS_CLK), .I_SRST(I_SRST), .I_MEM_REQ(I_MEM_REQ),
  .I_TBL_REQ(I_TBL_REQ), .I_PC(I_PC), .O_RDATA(O_RDATA), .O_BUSY(O_BUSY),
  .O_PM_ADDR(O_PM_ADDR), .O_PM_RD(O_PM_RD), .I_PM_DATA(I_PM_DATA));
`default_nettype wire

// ==== trb_pm_model.sv ====
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// Program memory model
// ----------------------------------------
module trb_pm_model #(
  parameter int PA_W = 11,
  parameter int PW_W = 15
) (
  input  wire logic            i_clk,
  input  wire logic [PA_W-1:0] i_addr,
  input  wire logic            i_rd,
  output logic [PW_W-1:0]      o_data
);
  logic [PW_W-1:0] last_q = '0;  // Last word driven
  // Word only during fetch; garbage otherwise so stale data shows
  always_comb o_data = i_rd ? PW_W'({i_addr, ~i_addr[7:0]}) : ~last_q;
  always_ff @(posedge i_clk) if (i_rd) last_q <= o_data;
endmodule : trb_pm_model
`default_nettype wire

// ==== trb_table_read_tb.sv ====
`timescale 1ns/100ps
`default_nettype none
module trb_table_read_tb;
  localparam int PA_W = 11;
  localparam int PW_W = 15;
  logic clk = 1'b0;
  logic srst = 1'b1;
  trb_pkg::trb_mem_req_t mreq = '0;
  trb_pkg::trb_tbl_req_t treq = '0;
  logic [PA_W-1:0] pc = '0;
  logic [7:0] rdata;
  logic busy, pm_rd;
  logic [PA_W-1:0] pm_addr;
  logic [PW_W-1:0] pm_data;
  int fail_count = 0;
  int samples_checked = 0;
  always #20 clk = ~clk;
  trb_table_read u_trb_table_read (.I_SYS_CLK(clk), .I_SRST(srst), .I_MEM_REQ(mreq), .I_TBL_REQ(treq),
    .I_PC(pc), .O_RDATA(rdata), .O_BUSY(busy), .O_PM_ADDR(pm_addr), .O_PM_RD(pm_rd), .I_PM_DATA(pm_data));
  trb_pm_model u_trb_pm_model (.i_clk(clk), .i_addr(pm_addr), .i_rd(pm_rd), .o_data(pm_data));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [PW_W-1:0] word(input logic [PA_W-1:0] a);
    return PW_W'({a, ~a[7:0]});
  endfunction : word
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic mem(input trb_pkg::trb_acc_t acc, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) mreq <= '{acc, a, d};
    @(posedge clk) mreq <= '{trb_pkg::TRB_ACC_NONE, 8'h00, 8'h00};
  endtask : mem
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    mem(trb_pkg::TRB_ACC_WRITE, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    mem(trb_pkg::TRB_ACC_READ, a, 8'h00);
    #1 check(rdata, exp);
  endtask : rd
  // One table read; checks busy and fetch address
  task automatic tbl(input logic lp, input logic [7:0] dst, input logic [PA_W-1:0] p, input logic [PA_W-1:0] ea);
    @(posedge clk) treq <= '{1'b1, lp, dst};
    pc <= p;
    #1 check(busy, 1'b1);
    @(posedge clk) treq <= '0;
    #1 check(pm_rd, 1'b1);
    check(pm_addr, ea);
  endtask : tbl
  task automatic final_report;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : final_report
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic sc_tables;
    wr(8'h07, 8'h06);
    tbl(1'b0, 8'h70, 11'h5a3, 11'h506);
    rd(8'h70, 8'(word(11'h506)));
    rd(8'h08, 8'(word(11'h506) >> 8));
    wr(8'h07, 8'h05);
    tbl(1'b1, 8'h71, 11'h123, 11'h705);
    rd(8'h71, 8'(word(11'h705)));
    rd(8'h08, 8'(word(11'h705) >> 8));
  endtask : sc_tables
  task automatic sc_latch_ro;
    wr(8'h08, 8'hff);
    rd(8'h08, 8'(word(11'h705) >> 8));
    // New pointer so the fetched high byte differs from the one already latched
    wr(8'h07, 8'h33);
    tbl(1'b0, 8'h08, 11'h2a3, 11'h233);
    rd(8'h08, 8'(word(11'h233) >> 8));
  endtask : sc_latch_ro
  task automatic sc_banks;
    wr(8'h04, 8'h00);
    wr(8'h80, 8'h11);
    wr(8'h60, 8'h33);
    wr(8'h04, 8'h01);
    wr(8'h80, 8'h22);
    rd(8'h80, 8'h22);
    rd(8'h07, 8'h33);
    wr(8'h04, 8'h00);
    rd(8'h80, 8'h11);
    rd(8'h60, 8'h33);
  endtask : sc_banks
  task automatic sc_nv_ctrl;
    wr(8'h40, 8'ha5);
    rd(8'h40, 8'h00);
    wr(8'h04, 8'h01);
    wr(8'h40, 8'h5a);
    rd(8'h40, 8'h5a);
    wr(8'h04, 8'h00);
    rd(8'h40, 8'h00);
  endtask : sc_nv_ctrl
  // Hang guard
  initial begin
    repeat (5000) @(posedge clk);
    fail_count++;
    final_report();
  end
  initial begin
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    sc_tables();
    sc_latch_ro();
    sc_banks();
    sc_nv_ctrl();
    final_report();
  end
endmodule : trb_table_read_tb
`default_nettype wire
